// ### include/pcr_pkg.sv
// pcr_pkg: constants shared by the configuration-register controller
// assumes a 250 MHz pclk and a 32-bit APB register port
package pcr_pkg;
   // clock period in ns
   localparam int CLK_NS = 4;

   // own APB register map (byte offsets)
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_CFG    = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_RDBK   = 12'h00c;
   localparam logic [11:0] OFF_FLOOR  = 12'h010;

   // reset values of own registers
   localparam logic [20:0] CFG_RST   = 21'h000070;
   localparam logic [1:0]  FLOOR_RST = 2'h2;

   // command codes written to the control register
   localparam logic [2:0] CMD_PIN_LOAD = 3'h1;
   localparam logic [2:0] CMD_SW_WRITE = 3'h2;
   localparam logic [2:0] CMD_SW_READ  = 3'h3;
   localparam logic [2:0] CMD_SLEEP    = 3'h4;
   localparam logic [2:0] CMD_WAKE     = 3'h5;

   // configuration word field positions
   localparam int BIT_PAGE   = 7;
   localparam int BIT_TEMP_H = 6;
   localparam int BIT_TEMP_L = 5;
   localparam int BIT_SLEEP  = 4;
   localparam int BIT_RSV_LO = 3;
   localparam int BIT_EXT_H  = 2;
   localparam int BIT_RSV_HI = 20;
   localparam int BIT_RSV_BL = 8;
   localparam int CFG_W      = 21;
   localparam int DATA_W     = 16;

   // top memory address used by the software access sequence
   localparam logic [20:0] TOP_ADDR = 21'h1fffff;
   // data of the third step of the software sequence
   localparam logic [15:0] SW_KEY   = 16'h0000;

   // temperature codes
   localparam logic [1:0] TEMP_85 = 2'h3;
   localparam logic [1:0] TEMP_70 = 2'h0;
   localparam logic [1:0] TEMP_45 = 2'h1;
   localparam logic [1:0] TEMP_15 = 2'h2;

   // pin timing in ns, and cycles derived from them
   localparam int T_CYC_NS  = 70;     // write or read cycle, least
   localparam int T_ZZWE_NS = 10;     // low-power pin low to write, least
   localparam int T_GAP_NS  = 5;      // chip deselect / high time, least
   localparam int T_ZZ_NS   = 10000;  // low-power pin hold, more than
   localparam int T_REC_NS  = 150000; // recovery after full shutdown
   localparam int CYC_ACC  = (T_CYC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_ZZWE = (T_ZZWE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_GAP  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_ZZ   = T_ZZ_NS / CLK_NS + 1;
   localparam int CYC_REC  = (T_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W    = 18;
endpackage

// ### verilog/pcr_timer.sv
// pcr_timer: down counter used for every pin wait of the controller
// assumes one clock, load is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module pcr_timer #(
   parameter int W = 18
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              done
);
   logic [W-1:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////
   // count down to zero and hold there
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // masked during load so a stale zero never ends the new wait
   assign done = (cnt_reg == '0) && !load;
endmodule // pcr_timer
`default_nettype wire

// ### verilog/pcr_ctrl.sv
// pcr_ctrl: host controller that loads and reads the memory's
// configuration register and steers its low-power modes
// assumes pins are synchronous to pclk and software uses APB
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - host clears bits twenty to eight and bit three on every load
// - host never programs a temperature below its configured floor
// - host changes full shutdown only through the pin load
// - host waits 150us after leaving full shutdown
// - pin held low over 10us enters sleep; high leaves it
// - write after pin fall loads address bits into the register
// - software access: two reads, a write, then a write or a read, top address
module pcr_ctrl #(
   parameter int REC_CYCLES = pcr_pkg::CYC_REC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [20:0] mem_addr,
   output logic      [15:0] mem_dq_out,
   input  wire logic [15:0] mem_dq_in,
   output logic             mem_dq_oe,
   output logic             mem_ce_n,
   output logic             mem_we_n,
   output logic             mem_oe_n,
   output logic             mem_ub_n,
   output logic             mem_lb_n,
   output logic             low_power_request_n
);
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_ZZ_WAIT = 4'h1,
      ST_PIN_WR  = 4'h3,
      ST_PIN_END = 4'h2,
      ST_SW_GAP  = 4'h6,
      ST_SW_ACC  = 4'h7,
      ST_SLP_HLD = 4'h5,
      ST_SLEEP   = 4'h4,
      ST_RECOVER = 4'hc
   } pcr_state_e;

   pcr_state_e                    state_reg;
   logic [pcr_pkg::CFG_W-1:0]     cfg_reg;
   logic [1:0]                    floor_reg;
   logic [pcr_pkg::DATA_W-1:0]    rdbk_reg;
   logic [2:0]                    step_reg;
   logic                          sw_rd_reg;
   logic                          sw_loaded_reg;
   logic                          par_sel_reg;
   logic                          lost_reg;
   logic                          refused_reg;
   logic                          tmr_load_reg;
   logic [pcr_pkg::TMR_W-1:0]     tmr_val_reg;
   logic                          tmr_done;
   logic [pcr_pkg::CFG_W-1:0]     word;
   logic [2:0]                    step_next;
   logic                          apb_do;
   logic                          cmd_go;
   logic [2:0]                    cmd;

   // ordering of temperature codes, coldest first
   function automatic logic [1:0] temp_rank(input logic [1:0] code);
      case (code)
         pcr_pkg::TEMP_15: temp_rank = 2'h0;
         pcr_pkg::TEMP_45: temp_rank = 2'h1;
         pcr_pkg::TEMP_70: temp_rank = 2'h2;
         default:          temp_rank = 2'h3;
      endcase
   endfunction

   // word put on the pins: reserved bits cleared, temperature floored
   function automatic logic [pcr_pkg::CFG_W-1:0] make_word(
      input logic [pcr_pkg::CFG_W-1:0] raw,
      input logic [1:0]                flr);
      logic [pcr_pkg::CFG_W-1:0] w;
      logic [1:0]                t;
      w = raw;
      t = raw[pcr_pkg::BIT_TEMP_H:pcr_pkg::BIT_TEMP_L];
      w[pcr_pkg::BIT_RSV_HI:pcr_pkg::BIT_RSV_BL] = '0;
      w[pcr_pkg::BIT_RSV_LO] = 1'b0;
      if (temp_rank(t) < temp_rank(flr)) begin
         t = flr;
      end
      w[pcr_pkg::BIT_TEMP_H:pcr_pkg::BIT_TEMP_L] = t;
      make_word = w;
   endfunction

   pcr_timer #(.W(pcr_pkg::TMR_W)) u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load_reg),
      .load_val (tmr_val_reg),
      .done     (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state so every answer comes from a flop
   assign apb_do = psel && penable && pready;
   assign cmd    = pwdata[2:0];
   assign cmd_go = apb_do && pwrite && (paddr[11:0] == pcr_pkg::OFF_CTRL);
   assign word   = make_word(cfg_reg, floor_reg);
   assign step_next = step_reg + 3'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && penable && !pready) begin
            case (paddr[11:0])
               pcr_pkg::OFF_CTRL: ;
               pcr_pkg::OFF_CFG: prdata <= {11'h000, cfg_reg};
               pcr_pkg::OFF_STATUS: prdata <= {26'h0000000,
                  refused_reg, lost_reg, sw_loaded_reg,
                  state_reg == ST_RECOVER, state_reg == ST_SLEEP,
                  state_reg != ST_IDLE};
               pcr_pkg::OFF_RDBK: prdata <= {16'h0000, rdbk_reg};
               pcr_pkg::OFF_FLOOR: prdata <= {30'h00000000, floor_reg};
               default: pslverr <= 1'b1; // unmapped
            endcase
         end
      end
   end

   // software-written settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg   <= pcr_pkg::CFG_RST;
         floor_reg <= pcr_pkg::FLOOR_RST;
      end else if (apb_do && pwrite) begin
         if (paddr[11:0] == pcr_pkg::OFF_CFG) begin
            cfg_reg <= pwdata[pcr_pkg::CFG_W-1:0];
         end
         if (paddr[11:0] == pcr_pkg::OFF_FLOOR) begin
            floor_reg <= pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer for the memory pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg           <= ST_IDLE;
         step_reg            <= 3'h0;
         sw_rd_reg           <= 1'b0;
         sw_loaded_reg       <= 1'b0;
         par_sel_reg         <= 1'b1;
         lost_reg            <= 1'b0;
         refused_reg         <= 1'b0;
         rdbk_reg            <= 16'h0000;
         tmr_load_reg        <= 1'b0;
         tmr_val_reg         <= '0;
         mem_addr            <= 21'h000000;
         mem_dq_out          <= 16'h0000;
         mem_dq_oe           <= 1'b0;
         mem_ce_n            <= 1'b1;
         mem_we_n            <= 1'b1;
         mem_oe_n            <= 1'b1;
         mem_ub_n            <= 1'b0;
         mem_lb_n            <= 1'b0;
         low_power_request_n <= 1'b1;
      end else begin
         tmr_load_reg <= 1'b0;
         // a command outside the idle state is not taken and is flagged, except wake in sleep
         if (cmd_go && state_reg != ST_IDLE && !(state_reg == ST_SLEEP
             && cmd == pcr_pkg::CMD_WAKE)) begin
            refused_reg <= 1'b1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (cmd_go) begin
                  refused_reg <= 1'b0;
                  case (cmd)
                     pcr_pkg::CMD_PIN_LOAD: begin
                        low_power_request_n <= 1'b0;
                        tmr_load_reg <= 1'b1;
                        tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_ZZWE);
                        state_reg    <= ST_ZZ_WAIT;
                     end
                     pcr_pkg::CMD_SW_WRITE, pcr_pkg::CMD_SW_READ: begin
                        sw_rd_reg    <= (cmd == pcr_pkg::CMD_SW_READ);
                        step_reg     <= 3'h7; // wraps to the first step
                        tmr_load_reg <= 1'b1;
                        tmr_val_reg  <= '0;
                        state_reg    <= ST_SW_GAP;
                     end
                     pcr_pkg::CMD_SLEEP: begin
                        // pin no longer starts partial refresh after
                        // a software load, so the request is refused
                        if (sw_loaded_reg && par_sel_reg) begin
                           refused_reg <= 1'b1;
                        end else begin
                           low_power_request_n <= 1'b0;
                           tmr_load_reg <= 1'b1;
                           tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_ZZ);
                           state_reg    <= ST_SLP_HLD;
                        end
                     end
                     default: refused_reg <= 1'b1;
                  endcase
               end
            end
            ST_ZZ_WAIT: begin
               if (tmr_done) begin
                  mem_addr     <= word;
                  mem_ce_n     <= 1'b0;
                  mem_we_n     <= 1'b0;
                  tmr_load_reg <= 1'b1;
                  tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_ACC);
                  state_reg    <= ST_PIN_WR;
               end
            end
            ST_PIN_WR: begin
               if (tmr_done) begin
                  mem_ce_n     <= 1'b1; // rising edge latches the word
                  mem_we_n     <= 1'b1;
                  par_sel_reg  <= word[pcr_pkg::BIT_SLEEP];
                  tmr_load_reg <= 1'b1;
                  tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_GAP);
                  state_reg    <= ST_PIN_END;
               end
            end
            ST_PIN_END: begin
               if (tmr_done) begin
                  low_power_request_n <= 1'b1;
                  state_reg           <= ST_IDLE;
               end
            end
            ST_SW_GAP: begin
               if (tmr_done) begin
                  if (step_reg == 3'h3) begin
                     // a software write always keeps partial refresh,
                     // full shutdown is changed only by the pin load
                     if (!sw_rd_reg) begin
                        sw_loaded_reg <= 1'b1;
                        par_sel_reg   <= 1'b1;
                     end
                     state_reg <= ST_IDLE;
                  end else begin
                     step_reg   <= step_next;
                     mem_addr   <= pcr_pkg::TOP_ADDR;
                     mem_ce_n   <= 1'b0;
                     mem_oe_n   <= !(step_next < 3'h2 ||
                                     (step_next == 3'h3 && sw_rd_reg));
                     mem_we_n   <= !(step_next == 3'h2 ||
                                     (step_next == 3'h3 && !sw_rd_reg));
                     mem_dq_oe  <= step_next == 3'h2 ||
                                   (step_next == 3'h3 && !sw_rd_reg);
                     mem_dq_out <= (step_next == 3'h3) ?
                        {word[15:pcr_pkg::BIT_SLEEP+1], 1'b1,
                         word[pcr_pkg::BIT_SLEEP-1:0]} : pcr_pkg::SW_KEY;
                     tmr_load_reg <= 1'b1;
                     tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_ACC);
                     state_reg    <= ST_SW_ACC;
                  end
               end
            end
            ST_SW_ACC: begin
               if (tmr_done) begin
                  if (step_reg == 3'h3 && sw_rd_reg) begin
                     rdbk_reg <= mem_dq_in;
                  end
                  mem_ce_n     <= 1'b1;
                  mem_oe_n     <= 1'b1;
                  mem_we_n     <= 1'b1;
                  mem_dq_oe    <= 1'b0;
                  tmr_load_reg <= 1'b1;
                  tmr_val_reg  <= pcr_pkg::TMR_W'(pcr_pkg::CYC_GAP);
                  state_reg    <= ST_SW_GAP;
               end
            end
            ST_SLP_HLD: begin
               if (tmr_done) begin
                  if (!par_sel_reg) begin
                     lost_reg <= 1'b1;
                  end
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (cmd_go && cmd == pcr_pkg::CMD_WAKE) begin
                  low_power_request_n <= 1'b1;
                  if (!par_sel_reg) begin
                     // recovery is long; the count is a parameter
                     tmr_load_reg <= 1'b1;
                     tmr_val_reg  <= pcr_pkg::TMR_W'(REC_CYCLES);
                     state_reg    <= ST_RECOVER;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_RECOVER: begin
               if (tmr_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // pcr_ctrl
`default_nettype wire

// ### tb/pcr_ctrl_chk.sv
// pcr_ctrl_chk: concurrent checks on the controller's bus and memory pins
// assumes it is bound to pcr_ctrl and that pcr_pkg is compiled first
`timescale 1ns/10ps
`default_nettype none
module pcr_ctrl_chk #(
   parameter int REC_CYCLES = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [20:0] mem_addr,
   input wire logic [15:0] mem_dq_out,
   input wire logic        mem_dq_oe,
   input wire logic        mem_ce_n,
   input wire logic        mem_we_n,
   input wire logic        low_power_request_n
);
   logic [11:0] zz_lo;
   logic [5:0]  ce_lo;
   logic [17:0] rec_cnt;
   logic        dpd_sel;
   logic [1:0]  floor_q;
   wire         pin_wr = !mem_ce_n && !mem_we_n && !low_power_request_n;
   wire         sw_acc = !mem_ce_n && low_power_request_n;
   // order of temperature codes from coldest to hottest
   function automatic logic [1:0] rank(input logic [1:0] t);
      return {t == 2'h0 || t == 2'h3, t == 2'h1 || t == 2'h3};
   endfunction
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // low-time counters; a pin load holds the pin low far shorter than sleep
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) begin
         zz_lo <= 12'h0;
         ce_lo <= 6'h0;
      end else begin
         zz_lo <= low_power_request_n ? 12'h0 : zz_lo + 12'(!(&zz_lo));
         ce_lo <= mem_ce_n ? 6'h0 : ce_lo + 6'h1;
      end
   // full-shutdown choice of the last load (set by a pin load only) and the quiet span after full shutdown
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) begin
         dpd_sel <= 1'b0;
         rec_cnt <= 18'h0;
      end else begin
         if (pin_wr || (sw_acc && !mem_we_n && mem_dq_out[4]))
            dpd_sel <= pin_wr && !mem_addr[4];
         if ($rose(low_power_request_n) && zz_lo > 12'd1000 && dpd_sel)
            rec_cnt <= 18'(REC_CYCLES);
         else if (rec_cnt != 18'h0)
            rec_cnt <= rec_cnt - 18'h1;
      end
   // temperature floor as last written by software
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         floor_q <= pcr_pkg::FLOOR_RST;
      else if (psel && penable && pready && pwrite &&
               paddr[11:0] == pcr_pkg::OFF_FLOOR)
         floor_q <= pwdata[1:0];
   ////////////////////////////////////////////////////////////////////////
   a_rsv_bits_zero: assert property (
      pin_wr |-> mem_addr[20:8] == 13'h0 && !mem_addr[3])
      else $error("reserved bit set in loaded word");
   a_temp_floor: assert property (
      pin_wr |-> rank(mem_addr[6:5]) >= rank(floor_q))
      else $error("loaded temperature below floor");
   a_sw_top_addr: assert property (
      sw_acc |-> mem_addr == pcr_pkg::TOP_ADDR)
      else $error("software access off the top address");
   a_sw_sleep_bit: assert property (
      sw_acc && !mem_we_n |-> mem_dq_oe &&
         (mem_dq_out == pcr_pkg::SW_KEY || mem_dq_out[4]))
      else $error("software write would select full shutdown");
   a_zz_to_write: assert property (
      $fell(low_power_request_n) |-> mem_we_n [*3])
      else $error("write too soon after pin fall");
   a_strobe_width: assert property (
      $rose(mem_ce_n) |-> ce_lo >= pcr_pkg::CYC_ACC)
      else $error("access strobe too short");
   a_strobe_gap: assert property ($rose(mem_ce_n) |-> mem_ce_n [*2])
      else $error("deselect gap too short");
   a_rec_quiet: assert property (rec_cnt != 18'h0 |-> mem_ce_n)
      else $error("access during shutdown recovery");
   a_ready_wait: assert property (
      psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("ready not after one wait cycle");
   a_err_map: assert property (pready && paddr[1:0] == 2'h0 |->
      pslverr == (paddr[11:0] > pcr_pkg::OFF_FLOOR))
      else $error("error response does not match the map");
   c_pin_load: cover property (pin_wr);
   c_recovery: cover property (rec_cnt == 18'h1);
   c_sw_write: cover property (sw_acc && !mem_we_n && mem_dq_out[4]);
   c_slverr: cover property (pready && pslverr);
endmodule // pcr_ctrl_chk
`default_nettype wire

// ### tb/pcr_mem_model.sv
// pcr_mem_model: behavioural memory that holds the configuration register
// assumes strobes from the controller; the model has no clock of its own
`timescale 1ns/10ps
`default_nettype none
module pcr_mem_model #(
   parameter real REC_NS = 200.0
) (
   input  wire logic [20:0] mem_addr,
   input  wire logic [15:0] mem_dq_out,
   input  wire logic        mem_ce_n,
   input  wire logic        mem_we_n,
   input  wire logic        mem_oe_n,
   input  wire logic        low_power_request_n,
   output logic      [15:0] mem_dq_in,
   output logic      [20:0] cfg_val,
   output int               n_dpd,
   output int               n_par,
   output int               n_viol
);
   logic        is_wr = 1'b0;
   logic        armed = 1'b0;
   logic        sw_done = 1'b0;
   logic [15:0] last_q = 16'h5a5a;
   int          step = 0;
   realtime     t_lo = 0;
   realtime     t_ready = 0;
   // power-up defaults
   initial begin
      cfg_val = 21'h000070;
      n_dpd = 0;
      n_par = 0;
      n_viol = 0;
   end
   // a released bus shows the inverse of its last value, never a hold
   assign mem_dq_in = (!mem_ce_n && !mem_oe_n && mem_we_n) ?
                      (step == 3 ? cfg_val[15:0] : 16'h3c3c) : ~last_q;
   ////////////////////////////////////////////////////////////////////////
   // access start: direction, and no access while recovering
   always @(negedge mem_ce_n) begin
      #1 is_wr = !mem_we_n;
      if ($realtime < t_ready)
         n_viol++;
   end
   // access end: pin load or one step of the software sequence
   always @(posedge mem_ce_n) begin
      if (!is_wr)
         last_q = (step == 3) ? cfg_val[15:0] : 16'h3c3c;
      if (armed && is_wr) begin
         cfg_val = mem_addr;
         if (mem_addr[20:8] != 13'h0 || mem_addr[3])
            n_viol++;
      end else if (mem_addr == 21'h1fffff) begin
         if (step == 3 && is_wr) begin
            cfg_val[15:0] = mem_dq_out;
            sw_done = 1'b1;
            if (!mem_dq_out[4])
               n_viol++;
         end
         step = (step == 3 || (step < 2 && is_wr) || (step == 2 && !is_wr))
                ? 0 : step + 1;
      end else
         step = 0;
      armed = 1'b0;
   end
   // pin fall arms a register load
   always @(negedge low_power_request_n) begin
      armed = 1'b1;
      t_lo = $realtime;
   end
   // sleep counts only once the pin was held low past the minimum
   always @(posedge low_power_request_n) begin
      if ($realtime - t_lo > 10000.0) begin
         if (!cfg_val[4]) begin
            n_dpd++;
            t_ready = $realtime + REC_NS;
         end else if (!sw_done)
            n_par++;
      end
      armed = 1'b0;
   end
endmodule // pcr_mem_model
`default_nettype wire

// ### tb/pcr_ctrl_tb_top.sv
// pcr_ctrl_tb_top: directed tests of the configuration-register controller
// assumes package, design, model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module pcr_ctrl_tb_top;
   localparam int REC = 50;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_q;
   logic        pready, pslverr, err_q, mem_dq_oe;
   logic        mem_ce_n, mem_we_n, mem_oe_n, mem_ub_n, mem_lb_n;
   logic        low_power_request_n;
   logic [20:0] mem_addr, cfg_val, w;
   logic [15:0] mem_dq_out, mem_dq_in;
   int          n_dpd, n_par, n_viol;
   int          num_errors = 0, n_compared = 0;
   always #(pcr_pkg::CLK_NS / 2.0) pclk = ~pclk;
   pcr_ctrl #(.REC_CYCLES(REC)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
      .mem_dq_in(mem_dq_in), .mem_dq_oe(mem_dq_oe), .mem_ce_n(mem_ce_n),
      .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_ub_n(mem_ub_n),
      .mem_lb_n(mem_lb_n), .low_power_request_n(low_power_request_n));
   pcr_mem_model #(.REC_NS(REC * 4.0)) mem (.mem_addr(mem_addr),
      .mem_dq_out(mem_dq_out), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
      .mem_oe_n(mem_oe_n), .low_power_request_n(low_power_request_n),
      .mem_dq_in(mem_dq_in), .cfg_val(cfg_val), .n_dpd(n_dpd),
      .n_par(n_par), .n_viol(n_viol));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one transfer; ends after an idle cycle so calls never collide
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= 32'(a);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_st(input logic [31:0] mask, input logic [31:0] v);
      do apb(1'b0, pcr_pkg::OFF_STATUS, 32'h0); while ((rd_q & mask) !== v);
   endtask
   task automatic cmd(input logic [2:0] c);
      apb(1'b1, pcr_pkg::OFF_CTRL, 32'(c));
      wait_st(32'h1, 32'h0);
   endtask
   task automatic pin_load(input logic [20:0] word);
      apb(1'b1, pcr_pkg::OFF_CFG, 32'(word));
      cmd(pcr_pkg::CMD_PIN_LOAD);
   endtask
   task automatic close_out;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog well beyond two sleep waits and all loads
   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      close_out;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, pcr_pkg::OFF_CFG, 32'h0);
      check(rd_q, 32'(pcr_pkg::CFG_RST));
      apb(1'b0, pcr_pkg::OFF_FLOOR, 32'h0);
      check(rd_q, 32'(pcr_pkg::FLOOR_RST));
      apb(1'b0, 12'h014, 32'h0);
      check({31'h0, err_q}, 32'h1);
      check(rd_q, 32'h0);
      // reserved bits set on purpose; all temps, extents and page values
      for (int i = 0; i < 8; i++) begin
         w = {13'h1fff, i[0], i[2:1], 2'h3, i[2:0]};
         pin_load(w);
         check(32'(cfg_val), 32'(w & 21'hf7));
      end
      apb(1'b1, pcr_pkg::OFF_FLOOR, 32'h0);
      pin_load(21'h000030);
      check(32'(cfg_val), 32'h10);
      apb(1'b1, pcr_pkg::OFF_FLOOR, 32'h2);
      // partial refresh sleep, then full shutdown with recovery
      for (int k = 0; k < 2; k++) begin
         pin_load(k ? 21'h000060 : 21'h000070);
         apb(1'b1, pcr_pkg::OFF_CTRL, 32'(pcr_pkg::CMD_SLEEP));
         wait_st(32'h2, 32'h2);
         apb(1'b1, pcr_pkg::OFF_CTRL, 32'(pcr_pkg::CMD_WAKE));
         apb(1'b0, pcr_pkg::OFF_STATUS, 32'h0);
         check(32'(rd_q[2]), 32'(k));
         wait_st(32'h7, 32'h0);
      end
      check(32'(n_par), 32'h1);
      check(32'(n_dpd), 32'h1);
      check(32'(rd_q[4]), 32'h1);
      // command while busy is refused, the next one is taken
      apb(1'b1, pcr_pkg::OFF_CTRL, 32'(pcr_pkg::CMD_PIN_LOAD));
      apb(1'b1, pcr_pkg::OFF_CTRL, 32'(pcr_pkg::CMD_SW_READ));
      wait_st(32'h1, 32'h0);
      check(32'(rd_q[5]), 32'h1);
      cmd(pcr_pkg::CMD_SW_READ);
      apb(1'b0, pcr_pkg::OFF_RDBK, 32'h0);
      check(rd_q, 32'h60);
      // software load keeps the sleep bit set and blocks the sleep command
      apb(1'b1, pcr_pkg::OFF_CFG, 32'h25);
      cmd(pcr_pkg::CMD_SW_WRITE);
      check(32'(cfg_val), 32'h35);
      apb(1'b1, pcr_pkg::OFF_CTRL, 32'(pcr_pkg::CMD_SLEEP));
      apb(1'b0, pcr_pkg::OFF_STATUS, 32'h0);
      check(rd_q & 32'h2a, 32'h28);
      check(32'(low_power_request_n), 32'h1);
      check(32'(n_viol), 32'h0);
      check(32'({mem_ub_n, mem_lb_n}), 32'h0);
      close_out;
   end
endmodule // pcr_ctrl_tb_top
bind pcr_ctrl pcr_ctrl_chk #(.REC_CYCLES(REC_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
   .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
   .low_power_request_n(low_power_request_n));
`default_nettype wire
